// ===== logic/dpwsem_cnt.v
// Down counter that times one phase of a port cycle.
// Assumes the caller loads it only when it is idle or restarting a phase.
`timescale 1ns/1ps
`default_nettype none
module dpwsem_cnt #(
  parameter W = 4
) (
  input wire ref_clk_i,
  input wire rstn_i,
  input wire en_i,
  input wire load_i,
  input wire [W-1:0] val_i,
  output wire done_o
);
  reg [W-1:0] cnt_q;
  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      cnt_q <= {W{1'b0}};
    end else if (en_i) begin
      if (load_i) begin
        cnt_q <= val_i;
      end else if (cnt_q != {W{1'b0}}) begin
        cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
  assign done_o = (cnt_q == {W{1'b0}});
endmodule
`default_nettype wire

// ===== logic/dpwsem_host.v
// Host controller that drives one port of an asynchronous dual-port RAM:
// array writes and reads, semaphore writes and read-backs.
// Assumes the RAM pins are sampled synchronously to ref_clk_i.
// Assumes one request at a time, with req_valid_i held until req_ready_o takes it.
// Functional notes
// - Array access uses port select low with semaphore select high, semaphore access the reverse.
// - The chosen select pair stays stable for at least the select-to-end-of-write time.
// - Strobe or port select is high whenever the address changes.
// - With output enable low the write pulse covers turn-off plus data set-up.
// - Write data stays valid for the hold time after the end of write.
// - Write data is not driven while the device may still drive the data pins.
// - Recovery counts from the first of port select or strobe rising, at least 0 ns.
// - Semaphore write then read keeps port select high and waits the write-to-read time.
`timescale 1ns/1ps
`default_nettype none
`include "dpwsem_map.vh"
module dpwsem_host #(
  parameter AW = 16,
  parameter DW = 8
) (
  input wire ref_clk_i,
  input wire rstn_i,
  input wire ce_i,
  input wire req_valid_i,
  input wire [1:0] req_op_i,
  input wire [AW-1:0] req_addr_i,
  input wire [DW-1:0] req_wdata_i,
  output reg req_ready_o,
  output reg rsp_valid_o,
  output reg [DW-1:0] rsp_rdata_o,
  output reg sem_flag_o,
  output reg port_sel_n_o,
  output reg semaphore_select_n_o,
  output reg rw_n_o,
  output reg oe_n_o,
  output reg [AW-1:0] addr_o,
  output reg [DW-1:0] data_o,
  output reg data_oe_o,
  input wire [DW-1:0] data_i
);
  // Whole-cycle counts; the 4-bit counter takes counts up to 15 and a larger count wraps,
  // so a much faster clock with a slow speed grade needs a wider counter
  localparam integer N_AS = `DPWSEM_CYC(`DPWSEM_T_AS_NS);
  localparam integer N_STRB = `DPWSEM_CYC(`DPWSEM_T_WZ_NS + `DPWSEM_T_DW_NS);
  localparam integer N_WP = `DPWSEM_CYC(`DPWSEM_T_WP_NS);
  localparam integer N_EW = `DPWSEM_CYC(`DPWSEM_T_EW_NS);
  localparam integer N_DH = `DPWSEM_CYC(`DPWSEM_T_DH_NS);
  localparam integer N_WR = `DPWSEM_CYC(`DPWSEM_T_WR_NS);
  localparam integer N_SWRD = `DPWSEM_CYC(`DPWSEM_T_SWRD_NS);
  localparam integer N_AA = `DPWSEM_CYC(`DPWSEM_T_AA_NS);
  localparam [3:0] C_AS = N_AS[3:0];
  localparam [3:0] C_STRB = N_STRB[3:0];
  localparam [3:0] C_WP = N_WP[3:0];
  localparam [3:0] C_EW = N_EW[3:0];
  localparam [3:0] C_DH = N_DH[3:0];
  localparam [3:0] C_WR = N_WR[3:0];
  localparam [3:0] C_SWRD = N_SWRD[3:0];
  localparam [3:0] C_AA = N_AA[3:0];
  localparam [3:0] C_PULSE = (C_WP > C_STRB) ? C_WP : C_STRB;
  localparam [3:0] C_WPULSE = (C_PULSE > C_EW) ? C_PULSE : C_EW;
  // A write runs setup, strobe, hold and recovery; a read swaps strobe and hold
  // for one access phase, then recovers
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_SETUP = 3'h1;
  localparam [2:0] S_STROBE = 3'h2;
  localparam [2:0] S_HOLD = 3'h3;
  localparam [2:0] S_RECOV = 3'h4;
  localparam [2:0] S_READ = 3'h5;
  reg [2:0] state_q;
  reg [1:0] op_q;
  reg sem_recent_q;
  reg load;
  reg [3:0] load_val;
  wire done;
  dpwsem_cnt #(
    .W(4)
  ) u_cnt (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .en_i(ce_i),
    .load_i(load),
    .val_i(load_val),
    .done_o(done)
  );
  wire is_write = (op_q == `DPWSEM_OP_RAM_WR) || (op_q == `DPWSEM_OP_SEM_WR);
  wire is_sem = (op_q == `DPWSEM_OP_SEM_WR) || (op_q == `DPWSEM_OP_SEM_RD);
  // The clock enable gates the take in the state register and in the counter
  wire take = req_valid_i && req_ready_o;
  wire sem_after_wr = (req_op_i == `DPWSEM_OP_SEM_RD) && sem_recent_q;
  always @* begin
    load = 1'b0;
    load_val = 4'h0;
    case (state_q)
      S_IDLE: begin
        if (take) begin
          load = 1'b1;
          load_val = sem_after_wr ? C_SWRD : C_AS;
        end
      end
      S_SETUP: begin
        if (done) begin
          load = 1'b1;
          load_val = is_write ? C_WPULSE : C_AA;
        end
      end
      S_STROBE: begin
        if (done) begin
          load = 1'b1;
          load_val = C_DH;
        end
      end
      S_HOLD: begin
        if (done) begin
          load = 1'b1;
          load_val = C_WR;
        end
      end
      S_READ: begin
        load = 1'b0;
      end
      S_RECOV: begin
        load = 1'b0;
      end
      default: begin
        load = 1'b0;
      end
    endcase
  end
  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      state_q <= S_IDLE;
      op_q <= 2'h0;
      sem_recent_q <= 1'b0;
      req_ready_o <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= {DW{1'b0}};
      sem_flag_o <= 1'b0;
      port_sel_n_o <= 1'b1;
      semaphore_select_n_o <= 1'b1;
      rw_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      addr_o <= {AW{1'b0}};
      data_o <= {DW{1'b0}};
      data_oe_o <= 1'b0;
    end else if (ce_i) begin
      rsp_valid_o <= 1'b0;
      case (state_q)
        S_IDLE: begin
          req_ready_o <= 1'b1;
          if (take) begin
            req_ready_o <= 1'b0;
            op_q <= req_op_i;
            // Address moves only while both selects and the strobe are high
            addr_o <= req_addr_i;
            data_o <= req_wdata_i;
            // A semaphore read right after a semaphore write waits out the update time
            if (req_op_i != `DPWSEM_OP_SEM_RD) begin
              sem_recent_q <= 1'b0;
            end
            state_q <= S_SETUP;
          end
        end
        S_SETUP: begin
          if (done) begin
            // On a write, select and strobe fall together, so the device keeps its outputs off
            port_sel_n_o <= is_sem;
            semaphore_select_n_o <= ~is_sem;
            rw_n_o <= ~is_write;
            oe_n_o <= is_write;
            // Device outputs are already off with the strobe low at select time
            data_oe_o <= is_write;
            state_q <= is_write ? S_STROBE : S_READ;
          end
        end
        S_STROBE: begin
          if (done) begin
            // Strobe and selects rise together; data stays driven through the hold
            rw_n_o <= 1'b1;
            port_sel_n_o <= 1'b1;
            semaphore_select_n_o <= 1'b1;
            sem_recent_q <= is_sem;
            state_q <= S_HOLD;
          end
        end
        S_HOLD: begin
          if (done) begin
            data_oe_o <= 1'b0;
            state_q <= S_RECOV;
          end
        end
        S_READ: begin
          if (done) begin
            // Data is taken a full access phase after the selects fell
            rsp_valid_o <= 1'b1;
            rsp_rdata_o <= data_i;
            // All data bits carry the flag; bit 0 low means this port holds it
            sem_flag_o <= is_sem ? data_i[0] : sem_flag_o;
            if (is_sem) begin
              sem_recent_q <= 1'b0;
            end
            port_sel_n_o <= 1'b1;
            semaphore_select_n_o <= 1'b1;
            oe_n_o <= 1'b1;
            state_q <= S_RECOV;
          end
        end
        S_RECOV: begin
          // Ready rises one cycle later so it always leaves a flip-flop
          state_q <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== logic/dpwsem_map.vh
// Timing constants and pin conventions for the dual-port RAM host controller.
// Assumes a 25 MHz clock; cycle counts are derived from times in ns.
`ifndef DPWSEM_MAP_VH
`define DPWSEM_MAP_VH
`define DPWSEM_CLK_PERIOD_NS 40
// Select to end of write, fastest grade
`define DPWSEM_T_EW_NS 12
// Write pulse width
`define DPWSEM_T_WP_NS 12
// Write enable to output high-z
`define DPWSEM_T_WZ_NS 10
// Data valid to end of write
`define DPWSEM_T_DW_NS 10
// Data hold after end of write
`define DPWSEM_T_DH_NS 0
// Write recovery
`define DPWSEM_T_WR_NS 0
// Semaphore flag write to read
`define DPWSEM_T_SWRD_NS 5
// Read access (address access, fastest grade)
`define DPWSEM_T_AA_NS 15
// Address set-up before select
`define DPWSEM_T_AS_NS 0
// Least-time round-up with a floor of one cycle
`define DPWSEM_CYC(t) (((t) + `DPWSEM_CLK_PERIOD_NS - 1) / `DPWSEM_CLK_PERIOD_NS < 1 ? 1 : \
  ((t) + `DPWSEM_CLK_PERIOD_NS - 1) / `DPWSEM_CLK_PERIOD_NS)
`define DPWSEM_OP_RAM_WR 2'h0
`define DPWSEM_OP_SEM_WR 2'h1
`define DPWSEM_OP_SEM_RD 2'h2
`define DPWSEM_OP_RAM_RD 2'h3
`endif

// ===== sim/dpwsem_checker.sv
// Assertions on the host controller pins.
// Assumes the ports of dpwsem_host; bound below.
`timescale 1ns/1ps
`default_nettype none
module dpwsem_checker #(
  parameter AW = 16,
  parameter DW = 8
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic req_valid_i,
  input wire logic [1:0] req_op_i,
  input wire logic req_ready_o,
  input wire logic rsp_valid_o,
  input wire logic port_sel_n_o,
  input wire logic semaphore_select_n_o,
  input wire logic rw_n_o,
  input wire logic oe_n_o,
  input wire logic [AW-1:0] addr_o,
  input wire logic [DW-1:0] data_o,
  input wire logic data_oe_o
);
  wire logic tk = ce_i && req_valid_i && req_ready_o;
  wire logic ps = port_sel_n_o;
  wire logic ss = semaphore_select_n_o;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  a_one_sel: assert property (!ps || !ss |-> ps != ss) else $error("selects");
  a_addr_move: assert property ($changed(addr_o) |-> (rw_n_o || ps) &&
    ($past(rw_n_o) || $past(ps))) else $error("address moved");
  a_pulse_off: assert property ($fell(rw_n_o) |-> oe_n_o && data_oe_o) else $error("pulse");
  a_data_hold: assert property ($rose(rw_n_o) |-> data_oe_o && $stable(data_o))
    else $error("hold");
  a_no_clash: assert property (!oe_n_o |-> !data_oe_o) else $error("clash");
  a_flag_gap: assert property ($rose(ss) |=> ss) else $error("gap");
  a_write_time: assert property (tk && !req_op_i[1] |=> !req_ready_o [*8] ##1 req_ready_o)
    else $error("write length");
  a_read_time: assert property (tk && req_op_i[1] |-> ##5 rsp_valid_o)
    else $error("read length");
  c_flag_wr: cover property (tk && req_op_i == 2'h1);
  c_flag_rd: cover property (tk && req_op_i == 2'h2);
  c_ram_wr: cover property ($fell(rw_n_o) && !ps);
  c_ram_rd: cover property (tk && req_op_i == 2'h3);
endmodule
bind dpwsem_host dpwsem_checker #(.AW(AW), .DW(DW)) u_chk (
  .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .req_valid_i(req_valid_i),
  .req_op_i(req_op_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
  .port_sel_n_o(port_sel_n_o), .semaphore_select_n_o(semaphore_select_n_o),
  .rw_n_o(rw_n_o), .oe_n_o(oe_n_o), .addr_o(addr_o), .data_o(data_o), .data_oe_o(data_oe_o)
);
`default_nettype wire

// ===== sim/dpwsem_ram.sv
// Model of one RAM port: array, eight flags, data pins.
// Assumes host pins change just after ref_clk_i rises.
`timescale 1ns/1ps
`default_nettype none
module dpwsem_ram (
  input wire logic ref_clk_i,
  input wire logic ps_n_i,
  input wire logic ss_n_i,
  input wire logic rw_n_i,
  input wire logic oe_n_i,
  input wire logic [15:0] a_i,
  input wire logic [7:0] d_i,
  input wire logic drv_i,
  output logic [7:0] q_o
);
  logic [7:0] mem [0:65535];
  logic [7:0] flag = 8'hff;
  logic [7:0] last = 8'h00;
  wire logic one = ps_n_i != ss_n_i;
  // Released pins toggle so a stale value never passes
  always @* begin
    if (drv_i) q_o = d_i;
    else if (oe_n_i || !rw_n_i || !one) q_o = ~last;
    else q_o = ss_n_i ? mem[a_i] : {8{flag[a_i[2:0]]}};
  end
  always @(posedge ref_clk_i) begin
    last <= q_o;
    if (!rw_n_i && one && !ps_n_i) mem[a_i] <= d_i;
    // A lone port always wins the flag
    if (!rw_n_i && one && ps_n_i) flag[a_i[2:0]] <= d_i[0];
  end
endmodule
`default_nettype wire

// ===== sim/dual_port_ram_write_and_semaphore_test.sv
// Bench for the dual-port RAM host controller.
// Assumes dpwsem_ram stands in for the RAM port.
`timescale 1ns/1ps
`default_nettype none
module dual_port_ram_write_and_semaphore_test;
  logic ref_clk_i = 1'h0, rstn_i = 1'h0, ce_i = 1'h1, req_valid_i = 1'h0;
  logic [1:0] req_op_i = 2'h0;
  logic [15:0] req_addr_i = 16'h0;
  logic [7:0] req_wdata_i = 8'h0;
  logic [7:0] m [8];
  logic [15:0] q [$];
  wire logic req_ready_o, rsp_valid_o, sem_flag_o, port_sel_n_o, semaphore_select_n_o;
  wire logic rw_n_o, oe_n_o, data_oe_o;
  wire logic [15:0] addr_o;
  wire logic [7:0] rsp_rdata_o, data_o, data_i;
  wire logic [5:0] pins = {req_ready_o, port_sel_n_o, semaphore_select_n_o, rw_n_o, oe_n_o,
    data_oe_o};
  int failures = 0, total_checks = 0, n;
  always #20 ref_clk_i = ~ref_clk_i;
  dpwsem_host dut (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .req_valid_i(req_valid_i),
    .req_op_i(req_op_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
    .sem_flag_o(sem_flag_o), .port_sel_n_o(port_sel_n_o),
    .semaphore_select_n_o(semaphore_select_n_o), .rw_n_o(rw_n_o), .oe_n_o(oe_n_o),
    .addr_o(addr_o), .data_o(data_o), .data_oe_o(data_oe_o), .data_i(data_i)
  );
  dpwsem_ram u_ram (.ref_clk_i(ref_clk_i), .ps_n_i(port_sel_n_o), .ss_n_i(semaphore_select_n_o),
    .rw_n_i(rw_n_o), .oe_n_i(oe_n_o), .a_i(addr_o), .d_i(data_o), .drv_i(data_oe_o), .q_o(data_i));
  task automatic check(input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %0t %h %h", $time, s, e);
    end
  endtask
  task automatic test_done;
    $display("%0d checks, %0d failures", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic run(input logic [1:0] op, input logic [15:0] a, input logic [7:0] d, e,
      input logic fz = 1'h0);
    logic [15:0] snap;
    @(posedge ref_clk_i);
    #1;
    {req_op_i, req_addr_i, req_wdata_i, req_valid_i} = {op, a, d, 1'h1};
    // A low enable must hold the six control pins in pins and leave the request waiting
    if (fz) begin
      ce_i = 1'h0;
      snap = 16'(pins);
      repeat (3) @(posedge ref_clk_i);
      #1;
      check(16'(pins), snap);
      ce_i = 1'h1;
    end
    n = 0;
    while (req_ready_o !== 1'h1 && n < 20) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    // Ready is settled high here, so the next edge takes the request
    @(posedge ref_clk_i);
    #1;
    req_valid_i = 1'h0;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end while ((op[1] ? rsp_valid_o : req_ready_o) !== 1'h1 && n < 20);
    check(16'(n), op[1] ? 16'h4 : 16'h8);
    if (op[1]) check(16'(rsp_rdata_o), 16'(e));
    if (op == 2'h2) check(16'(sem_flag_o), 16'(e[0]));
  endtask
  initial begin
    void'($urandom(32'hdd2e8e9c));
    repeat (2) @(posedge ref_clk_i);
    #1;
    rstn_i = 1'h1;
    check(16'({req_ready_o, port_sel_n_o, rw_n_o, data_oe_o}), 16'h6);
    for (int i = 0; i < 8; i++) begin
      // Low three address bits keep the eight test addresses distinct
      q.push_back(i == 0 ? 16'h0 : i == 7 ? 16'hffff : {13'($urandom), 3'(i)});
      m[i] = 8'($urandom);
      run(2'h0, q[i], m[i], 8'h0);
    end
    foreach (q[i]) run(2'h3, q[i], 8'h0, m[i], i == 2);
    $display("array test done");
    @(posedge ref_clk_i);
    #1;
    rstn_i = 1'h0;
    repeat (2) @(posedge ref_clk_i);
    #1;
    check(16'({rsp_valid_o, pins}), 16'h1e);
    rstn_i = 1'h1;
    $display("reset test done");
    for (int i = 0; i < 16; i++) begin
      run(2'h1, 16'(i / 2), {7'($urandom), i[0]}, 8'h0);
      run(2'h2, 16'(i / 2), 8'h0, {8{i[0]}});
    end
    $display("flag test done");
    test_done;
  end
  initial begin
    #100000;
    failures++;
    test_done;
  end
endmodule
`default_nettype wire
